// ===== inc/xaui_lane_pkg.sv
/*
  Shared constants and carrier types for the four-lane gap, compensation
  and serializer datapath. Assumes a single 100 MHz system clock and an
  AHB-Lite register bus with 32-bit data; the link clocks are sampled.
*/
package xaui_lane_pkg;

  // ***************************************************************
  // Codes
  // ***************************************************************
  localparam logic [7:0] BYTE_IDLE = 8'h07;
  localparam logic [7:0] BYTE_TERM = 8'hFD;
  localparam logic [7:0] CODE_ALIGN = 8'h7C;
  localparam logic [7:0] CODE_SYNC = 8'hBC;
  localparam logic [7:0] CODE_SKIP = 8'h1C;
  localparam logic [7:0] CODE_LSM = 8'h9C;
  localparam int LANES = 4;
  localparam int SYM_W = 10;

  // ***************************************************************
  // Gap generator and serializer timing
  // ***************************************************************
  localparam logic [4:0] ACNT_BASE = 5'h10;
  localparam logic [4:0] ACNT_ZERO = 5'h00;
  localparam logic [4:0] ACNT_ONE = 5'h01;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int KR_BIT = 4;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // ***************************************************************
  // Receive column buffer
  // ***************************************************************
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FILL_HI = 4'h6;
  localparam logic [3:0] FILL_LO = 4'h2;
  localparam logic [3:0] FILL_EMPTY = 4'h0;
  localparam logic [3:0] FILL_FULL = 4'h8;
  localparam logic [3:0] PTR_STEP = 4'h1;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ***************************************************************
  // Register map (index; byte address is four times the index)
  // ***************************************************************
  localparam logic [5:0] IDX_GLOBAL_CFG = 6'h10;
  localparam logic [5:0] IDX_LANE_CFG_FIRST = 6'h11;
  localparam logic [5:0] IDX_LANE_CFG_LAST = 6'h14;
  localparam logic [5:0] IDX_CTC_STATUS = 6'h18;
  localparam int GCFG_OVR_BIT = 0;
  localparam int GCFG_MODE_LSB = 1;
  localparam int GCFG_MODE_MSB = 2;
  localparam int GCFG_ENC_BIT = 3;
  localparam int GCFG_CTC_BIT = 11;
  localparam int LANE_PRE_LSB = 4;
  localparam int LANE_PRE_MSB = 5;
  localparam int STAT_FILL_LSB = 0;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_CHOICE_BIT = 6;
  localparam int STAT_INS_LSB = 8;
  localparam int STAT_DROP_LSB = 16;
  localparam logic GCFG_CTC_RESET = 1'b1;
  localparam logic GCFG_ENC_RESET = 1'b1;

  // ***************************************************************
  // Operating modes as {high pin, low pin}
  // ***************************************************************
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_RX_ONLY = 2'h1;
  localparam logic [1:0] MODE_TX_ONLY = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic [3:0] k;
    logic [3:0][7:0] d;
  } column_t;

  typedef enum logic {IPG_DATA, IPG_GAP} ipg_state_t;

  typedef enum logic [1:0] {EMPH_30, EMPH_20, EMPH_10, EMPH_OFF} emph_t;

endpackage

// ===== src/xaui_ipg_ctc_lane_datapath.sv
/*
  Four-lane datapath: gap column substitution, LSB-first serializers,
  receive skip compensation with idle conversion, operating mode and
  emphasis select, all behind an AHB-Lite register slave.
  Assumes both link clocks are far slower than mclk_i and are sampled.
*/
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module xaui_ipg_ctc_lane_datapath
  import xaui_lane_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Configuration pins
  input wire logic op_config_pin_low_i,
  input wire logic op_config_pin_high_i,
  // Transmit parallel side
  input wire logic tx_clock_lane_first_i,
  input wire column_t tx_lane_bytes_i,
  input wire logic [3:0][9:0] tx_lane_syms_i,
  // Serial side
  output logic [3:0] tx_serial_o,
  output logic [3:0] tx_serial_oe_o,
  input wire logic [3:0] rx_serial_i,
  // Receive parallel side
  input wire logic rx_clock_lane_first_i,
  input wire column_t rx_lane_column_i,
  output column_t rx_column_o,
  output logic rx_column_oe_o,
  // Power and emphasis
  output logic tx_power_up_o,
  output logic rx_power_up_o,
  output emph_t [3:0] emphasis_level_o
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic txclk_s1;
    logic txclk_s2;
    logic txclk_s3;
    logic rxclk_s1;
    logic rxclk_s2;
    logic rxclk_s3;
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    column_t txd_s1;
    column_t txd_s2;
    logic [3:0][9:0] txr_s1;
    logic [3:0][9:0] txr_s2;
    column_t rxd_s1;
    column_t rxd_s2;
    logic [3:0] rser_s1;
    logic [3:0] rser_s2;
    ipg_state_t ipg_state;
    logic choice_align;
    logic [4:0] acnt;
    logic [15:0] lfsr;
    logic [3:0][9:0] hold;
    logic [3:0][9:0] shreg;
    logic [3:0] bitcnt;
    logic [3:0] ser;
    column_t [FIFO_DEPTH-1:0] fifo;
    logic [3:0] wptr;
    logic [3:0] rptr;
    column_t rxo;
    logic [7:0] ins_cnt;
    logic [7:0] drop_cnt;
    logic ovr_en;
    logic [1:0] ovr_mode;
    logic enc_en;
    logic ctc_en;
    logic [3:0][1:0] lane_pre;
    logic dp_valid;
    logic dp_write;
    logic [5:0] dp_idx;
    logic [31:0] hrdata;
  } st_t;

  st_t st;
  st_t nxt;

  logic tx_edge;
  logic rx_edge;
  logic [1:0] mode;
  logic tx_active;
  logic rx_active;
  logic first_col;
  logic all_idle;
  logic any_term;
  logic send_a;
  logic send_k;
  logic send_r;
  logic [3:0] lane_idle;
  logic [3:0] lane_term;
  logic [3:0] in_skip;
  logic [3:0] head_skip;
  logic [3:0] ser_bit;
  logic [3:0][9:0] tx_sym;
  logic [3:0][9:0] shift_nxt;
  column_t head;
  column_t head_conv;
  logic [3:0] fill;
  logic accept;
  logic addr_ok;
  logic [5:0] a_idx;
  logic [1:0] wr_lane;
  logic [1:0] rd_lane;
  logic [31:0] rd_word;

  // ***************************************************************
  // Decode and gap column choice
  // ***************************************************************
  assign tx_edge = st.txclk_s2 & ~st.txclk_s3;
  assign rx_edge = st.rxclk_s2 & ~st.rxclk_s3;
  assign mode = st.ovr_en ? st.ovr_mode : st.cfg_s2;
  assign tx_active = (mode == MODE_FULL) || (mode == MODE_TX_ONLY);
  assign rx_active = (mode == MODE_FULL) || (mode == MODE_RX_ONLY);
  assign first_col = (st.ipg_state == IPG_DATA);
  assign all_idle = &lane_idle;
  assign any_term = |lane_term;
  // Alignment waits for the spacing counter; the gap opener also obeys
  // the alternating choice.
  assign send_a = all_idle && (st.acnt == ACNT_ZERO)
    && (!first_col || st.choice_align);
  assign send_k = all_idle && !send_a
    && (first_col || st.lfsr[KR_BIT]);
  assign send_r = all_idle && !send_a && !send_k;
  assign fill = st.wptr - st.rptr;
  assign head = st.fifo[st.rptr[2:0]];

  // ***************************************************************
  // Per-lane logic, lane 0 is lane A
  // ***************************************************************
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      logic [7:0] ob;
      assign lane_idle[i] = st.txd_s2.k[i]
        && (st.txd_s2.d[i] == BYTE_IDLE);
      assign lane_term[i] = st.txd_s2.k[i]
        && (st.txd_s2.d[i] == BYTE_TERM);
      // Link status columns carry no idle, so they pass unchanged.
      always_comb
      begin
        if (send_a)
          ob = CODE_ALIGN;
        else if (send_k)
          ob = CODE_SYNC;
        else if (send_r)
          ob = CODE_SKIP;
        else if (any_term && lane_idle[i])
          ob = CODE_SYNC;
        else
          ob = st.txd_s2.d[i];
      end
      assign tx_sym[i] = st.enc_en ? {1'b0, st.txd_s2.k[i], ob}
        : st.txr_s2[i];
      assign shift_nxt[i] = {1'b0, st.shreg[i][SYM_W-1:1]};
      assign ser_bit[i] = (mode == MODE_REPEAT) ? st.rser_s2[i]
        : st.shreg[i][0];
      assign in_skip[i] = st.rxd_s2.k[i]
        && (st.rxd_s2.d[i] == CODE_SKIP);
      assign head_skip[i] = head.k[i] && (head.d[i] == CODE_SKIP);
      assign head_conv.k[i] = head.k[i];
      assign head_conv.d[i] = (head.k[i] && ((head.d[i] == CODE_ALIGN)
        || (head.d[i] == CODE_SYNC) || head_skip[i]))
        ? BYTE_IDLE : head.d[i];
      always_comb
      begin
        case (st.lane_pre[i])
          2'h0: emphasis_level_o[i] = EMPH_30;
          2'h1: emphasis_level_o[i] = EMPH_20;
          2'h2: emphasis_level_o[i] = EMPH_10;
          default: emphasis_level_o[i] = EMPH_OFF;
        endcase
      end
    end
  endgenerate

  // ***************************************************************
  // Register bus decode
  // ***************************************************************
  assign accept = hsel_i && htrans_i[1] && hready_i;
  assign addr_ok = (haddr_i[31:8] == 24'h000000)
    && (haddr_i[1:0] == 2'h0);
  assign a_idx = haddr_i[7:2];
  assign wr_lane = 2'(st.dp_idx - IDX_LANE_CFG_FIRST);
  assign rd_lane = 2'(a_idx - IDX_LANE_CFG_FIRST);

  always_comb
  begin
    rd_word = 32'h00000000;
    if (!addr_ok)
      rd_word = 32'h00000000;
    else if (a_idx == IDX_GLOBAL_CFG)
    begin
      rd_word[GCFG_OVR_BIT] = st.ovr_en;
      rd_word[GCFG_MODE_MSB:GCFG_MODE_LSB] = st.ovr_mode;
      rd_word[GCFG_ENC_BIT] = st.enc_en;
      rd_word[GCFG_CTC_BIT] = st.ctc_en;
    end
    else if (a_idx >= IDX_LANE_CFG_FIRST && a_idx <= IDX_LANE_CFG_LAST)
      rd_word[LANE_PRE_MSB:LANE_PRE_LSB] = st.lane_pre[rd_lane];
    else if (a_idx == IDX_CTC_STATUS)
    begin
      rd_word[STAT_FILL_LSB +: 4] = fill;
      rd_word[STAT_MODE_LSB +: 2] = mode;
      rd_word[STAT_CHOICE_BIT] = st.choice_align;
      rd_word[STAT_INS_LSB +: 8] = st.ins_cnt;
      rd_word[STAT_DROP_LSB +: 8] = st.drop_cnt;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    nxt = st;
    // Pin and link inputs cross two flops before any logic reads them.
    nxt.txclk_s1 = tx_clock_lane_first_i;
    nxt.txclk_s2 = st.txclk_s1;
    nxt.txclk_s3 = st.txclk_s2;
    nxt.rxclk_s1 = rx_clock_lane_first_i;
    nxt.rxclk_s2 = st.rxclk_s1;
    nxt.rxclk_s3 = st.rxclk_s2;
    nxt.cfg_s1 = {op_config_pin_high_i, op_config_pin_low_i};
    nxt.cfg_s2 = st.cfg_s1;
    nxt.txd_s1 = tx_lane_bytes_i;
    nxt.txd_s2 = st.txd_s1;
    nxt.txr_s1 = tx_lane_syms_i;
    nxt.txr_s2 = st.txr_s1;
    nxt.rxd_s1 = rx_lane_column_i;
    nxt.rxd_s2 = st.rxd_s1;
    nxt.rser_s1 = rx_serial_i;
    nxt.rser_s2 = st.rser_s1;

    // Gap generator runs once per transmit column.
    if (tx_edge && tx_active)
    begin
      nxt.lfsr = {1'b0, st.lfsr[15:1]}
        ^ (st.lfsr[0] ? LFSR_TAPS : 16'h0000);
      nxt.hold = tx_sym;
      if (all_idle)
      begin
        nxt.ipg_state = IPG_GAP;
        if (first_col)
          nxt.choice_align = !send_a;
      end
      else
        nxt.ipg_state = IPG_DATA;
      if (send_a)
        nxt.acnt = ACNT_BASE + {1'b0, st.lfsr[3:0]};
      else if (st.acnt != ACNT_ZERO)
        nxt.acnt = st.acnt - ACNT_ONE;
    end

    // The shifter restarts on the newest symbol every ten bits; a column
    // that arrives mid-symbol only replaces the held one.
    if (st.bitcnt == BIT_LAST)
    begin
      nxt.bitcnt = 4'h0;
      nxt.shreg = st.hold;
    end
    else
    begin
      nxt.bitcnt = st.bitcnt + BIT_STEP;
      nxt.shreg = shift_nxt;
    end
    nxt.ser = ser_bit;

    // Receive column buffer: written on receive column, read on lane A.
    if (rx_edge && rx_active)
    begin
      if (st.ctc_en && (&in_skip) && fill >= FILL_HI)
        nxt.drop_cnt = st.drop_cnt + CNT_STEP;
      else if (fill != FILL_FULL)
      begin
        nxt.fifo[st.wptr[2:0]] = st.rxd_s2;
        nxt.wptr = st.wptr + PTR_STEP;
      end
    end
    if (tx_edge && rx_active)
    begin
      if (fill == FILL_EMPTY)
        nxt.rxo = '{k: 4'hF, d: {LANES{BYTE_IDLE}}};
      else if (st.ctc_en && (&head_skip) && fill <= FILL_LO)
      begin
        nxt.rxo = head_conv;
        nxt.ins_cnt = st.ins_cnt + CNT_STEP;
      end
      else
      begin
        nxt.rxo = head_conv;
        nxt.rptr = st.rptr + PTR_STEP;
      end
    end

    // Register bus.
    nxt.dp_valid = accept && addr_ok;
    nxt.dp_write = hwrite_i;
    nxt.dp_idx = a_idx;
    if (accept && !hwrite_i)
      nxt.hrdata = rd_word;
    if (st.dp_valid && st.dp_write)
    begin
      if (st.dp_idx == IDX_GLOBAL_CFG)
      begin
        nxt.ovr_en = hwdata_i[GCFG_OVR_BIT];
        nxt.ovr_mode = hwdata_i[GCFG_MODE_MSB:GCFG_MODE_LSB];
        nxt.enc_en = hwdata_i[GCFG_ENC_BIT];
        nxt.ctc_en = hwdata_i[GCFG_CTC_BIT];
      end
      else if (st.dp_idx >= IDX_LANE_CFG_FIRST
        && st.dp_idx <= IDX_LANE_CFG_LAST)
        nxt.lane_pre[wr_lane] = hwdata_i[LANE_PRE_MSB:LANE_PRE_LSB];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
      st.lfsr <= LFSR_SEED;
      st.ctc_en <= GCFG_CTC_RESET;
      st.enc_en <= GCFG_ENC_RESET;
    end
    else
      st <= nxt;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign hrdata_o = st.hrdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign tx_serial_o = st.ser;
  assign tx_serial_oe_o = (mode == MODE_RX_ONLY) ? 4'h0 : 4'hF;
  assign rx_column_o = st.rxo;
  assign rx_column_oe_o = (mode != MODE_TX_ONLY);
  assign tx_power_up_o = (mode != MODE_RX_ONLY);
  assign rx_power_up_o = (mode != MODE_TX_ONLY);

endmodule // xaui_ipg_ctc_lane_datapath

// ===== tb/xaui_ipg_ctc_lane_datapath_tb.sv
/*
  Self-checking bench: registers, modes, gap stream, raw symbols and
  receive compensation. Assumes the partner drives both column links.
*/
`timescale 1ns/1ps
module xaui_ipg_ctc_lane_datapath_tb
  import xaui_lane_pkg::*;
;
  logic mclk, resetn, hwrite, pin_lo, pin_hi, tx_clk, rx_clk, mon_on;
  logic tx_pkt;
  logic hreadyout, hresp, rx_oe, tx_pwr, rx_pwr;
  logic [1:0] htrans, rx_kind, v;
  logic [31:0] haddr, hwdata, hrdata, r, s0, s1;
  column_t tx_col, rx_col, rx_out;
  logic [3:0][9:0] syms;
  logic [3:0] ser, ser_oe, rx_ser, e;
  logic [7:0] rx_half = 8'd40;
  logic [9:0] win, raw, win2;
  emph_t [3:0] emph;
  int n_errors, n_compared, cyc, n_al, n_sy, n_id, n_raw, n_df;
  int n_lsm, n_ts, n_ti;
  xaui_ipg_ctc_lane_datapath uut (.mclk_i(mclk), .resetn_i(resetn),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .op_config_pin_low_i(pin_lo), .op_config_pin_high_i(pin_hi),
    .tx_clock_lane_first_i(tx_clk), .tx_lane_bytes_i(tx_col),
    .tx_lane_syms_i(syms), .tx_serial_o(ser), .tx_serial_oe_o(ser_oe),
    .rx_serial_i(rx_ser), .rx_clock_lane_first_i(rx_clk),
    .rx_lane_column_i(rx_col), .rx_column_o(rx_out),
    .rx_column_oe_o(rx_oe), .tx_power_up_o(tx_pwr),
    .rx_power_up_o(rx_pwr), .emphasis_level_o(emph));
  xaui_lane_partner partner (.rx_half_i(rx_half), .rx_kind_i(rx_kind),
    .tx_pkt_i(tx_pkt), .tx_clk_o(tx_clk), .tx_col_o(tx_col),
    .rx_clk_o(rx_clk), .rx_col_o(rx_col));
  // ***************************************************************
  // Tasks and expectations
  // ***************************************************************
  task automatic bus(input logic w, input logic [31:0] a, d,
    output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [35:0] x, g);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic emph_t exp_emph(input logic [1:0] b);
    exp_emph = (b == 2'h0) ? EMPH_30 : (b == 2'h1) ? EMPH_20 :
      (b == 2'h2) ? EMPH_10 : EMPH_OFF;
  endfunction
  function automatic logic [3:0] exp_mode(input logic [1:0] m);
    exp_mode = {m != MODE_RX_ONLY, m != MODE_TX_ONLY,
      m != MODE_RX_ONLY, m != MODE_TX_ONLY};
  endfunction
  // ***************************************************************
  // Clock, timeout and serial monitor
  // ***************************************************************
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  // Sampled on the falling edge so registered bits have settled.
  always @(negedge mclk)
    if (mon_on)
    begin
      win = {ser[0], win[9:1]};
      win2 = {ser[2], win2[9:1]};
      n_al += int'(win == {2'b01, CODE_ALIGN});
      n_sy += int'(win == {2'b01, CODE_SYNC});
      n_id += int'(win == {2'b01, BYTE_IDLE});
      n_raw += int'(win == raw);
      n_lsm += int'(win == {2'b01, CODE_LSM});
      n_ts += int'(win2 == {2'b01, CODE_SYNC});
      n_ti += int'(win2 == {2'b01, BYTE_IDLE});
      if (ser != 4'h0 && ser != 4'hF)
        n_df++;
    end
  initial
  begin
    void'($urandom(2));
    {mclk, resetn, hwrite, pin_lo, pin_hi, mon_on, tx_pkt} = '0;
    {htrans, haddr, hwdata, rx_ser, win, win2} = '0;
    rx_kind = 2'h2;
    raw = {2'b10, 8'($urandom)};
    syms = {4{raw}};
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 32'h40, 32'h0, r);
    chk("global cfg", 32'h808, r);
    bus(1'b0, 32'h7C, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    for (int l = 0; l < LANES; l++)
    begin
      v = 2'($urandom);
      bus(1'b1, 32'h44 + 32'(4 * l), {26'h0, v, 4'h0}, r);
      bus(1'b0, 32'h44 + 32'(4 * l), 32'h0, r);
      chk("lane cfg", v, r[5:4]);
      chk("emphasis", exp_emph(v), emph[l]);
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++)
    begin
      pin_lo <= m[0];
      pin_hi <= m[1];
      rx_ser <= 4'($urandom);
      repeat (12) @(posedge mclk);
      e = exp_mode(2'(m));
      chk("mode outputs", {{4{e[3]}}, e[2:0]},
        {ser_oe, rx_oe, tx_pwr, rx_pwr});
      if (m == 3)
        chk("repeated serial", rx_ser, ser);
    end
    pin_lo <= 1'b0;
    pin_hi <= 1'b0;
    bus(1'b1, 32'h40, 32'h80B, r);
    repeat (4) @(posedge mclk);
    chk("override oe", 4'h0, ser_oe);
    bus(1'b1, 32'h40, 32'h808, r);
    $display("test modes done");
    mon_on <= 1'b1;
    repeat (800) @(posedge mclk);
    chk("lanes differ", 0, n_df);
    chk("idle left", 0, n_id);
    chk("align seen", 1, n_al != 0);
    chk("sync seen", 1, n_sy != 0);
    bus(1'b1, 32'h40, 32'h800, r);
    n_raw = 0;
    repeat (200) @(posedge mclk);
    chk("raw symbol", 1, n_raw != 0);
    bus(1'b1, 32'h40, 32'h808, r);
    bus(1'b0, 32'h60, 32'h0, s0);
    chk("choice before", 1, s0[6]);
    tx_pkt <= 1'b1;
    repeat (60) @(posedge mclk);
    n_lsm = 0;
    n_ts = 0;
    n_ti = 0;
    repeat (400) @(posedge mclk);
    chk("status column", 1, n_lsm != 0);
    chk("terminate sync", 1, n_ts != 0);
    chk("terminate idle", 0, n_ti);
    tx_pkt <= 1'b0;
    mon_on <= 1'b0;
    repeat (60) @(posedge mclk);
    bus(1'b0, 32'h60, 32'h0, s0);
    chk("choice after", 0, s0[6]);
    $display("test transmit done");
    repeat (300) @(posedge mclk);
    chk("rx align idle", {4'hF, {4{BYTE_IDLE}}}, rx_out);
    rx_kind <= 2'h0;
    repeat (300) @(posedge mclk);
    chk("rx data k", 4'h0, rx_out.k);
    rx_kind <= 2'h1;
    rx_half <= 8'd36;
    bus(1'b0, 32'h60, 32'h0, s0);
    repeat (3000) @(posedge mclk);
    bus(1'b0, 32'h60, 32'h0, s1);
    chk("drop grew", 1, s1[23:16] != s0[23:16]);
    rx_half <= 8'd44;
    repeat (3000) @(posedge mclk);
    bus(1'b0, 32'h60, 32'h0, s0);
    chk("insert grew", 1, s0[15:8] != s1[15:8]);
    bus(1'b1, 32'h40, 32'h008, r);
    rx_half <= 8'd36;
    repeat (500) @(posedge mclk);
    bus(1'b0, 32'h60, 32'h0, s0);
    repeat (3000) @(posedge mclk);
    bus(1'b0, 32'h60, 32'h0, s1);
    chk("drop frozen", s0[23:16], s1[23:16]);
    $display("test receive done");
    end_sim();
  end
endmodule // xaui_ipg_ctc_lane_datapath_tb

// ===== tb/xaui_lane_assertions.sv
/*
  Port checker for the four-lane gap and compensation datapath.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module xaui_lane_assertions
  import xaui_lane_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Lane side
  input wire logic tx_clock_lane_first_i,
  input wire logic [3:0] tx_serial_oe_o,
  input wire column_t rx_column_o,
  input wire logic rx_column_oe_o,
  input wire logic tx_power_up_o,
  input wire logic rx_power_up_o,
  input wire emph_t [3:0] emphasis_level_o
);
  // ***************************************************************
  // Helper logic
  // ***************************************************************
  logic taken;
  logic tx_q_ff;
  logic wr_dp_ff;
  logic [3:0] since_ff;
  assign taken = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tx_q_ff <= 1'b0;
      wr_dp_ff <= 1'b0;
      since_ff <= 4'hF;
    end
    else
    begin
      tx_q_ff <= tx_clock_lane_first_i;
      wr_dp_ff <= taken && hwrite_i;
      if (tx_clock_lane_first_i && !tx_q_ff)
        since_ff <= 4'h0;
      else if (since_ff != 4'hF)
        since_ff <= since_ff + 4'h1;
    end
  end
  function automatic logic gap_code(input column_t c);
    gap_code = 1'b0;
    for (int l = 0; l < LANES; l++)
      if (c.k[l] && (c.d[l] == CODE_ALIGN || c.d[l] == CODE_SYNC ||
          c.d[l] == CODE_SKIP))
        gap_code = 1'b1;
  endfunction
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // A receive column may only move shortly after a transmit column edge.
  sequence tx_edge_recent;
    since_ff <= 4'h6;
  endsequence
  resp_okay_a: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
    else $error("bus answer is not a zero-wait OKAY");
  rdata_hold_a: assert property ($changed(hrdata_o)
    |-> $past(taken && !hwrite_i))
    else $error("read data moved without a read");
  emph_write_a: assert property ($changed(emphasis_level_o)
    |-> $past(wr_dp_ff))
    else $error("emphasis moved without a write");
  serial_float_a: assert property (
    tx_serial_oe_o == {4{tx_power_up_o}})
    else $error("serial enable disagrees with transmit power");
  rxbus_float_a: assert property (
    rx_column_oe_o == rx_power_up_o)
    else $error("receive bus enable disagrees with receive power");
  power_any_a: assert property (tx_power_up_o || rx_power_up_o)
    else $error("both paths powered down");
  rx_idle_conv_a: assert property (!gap_code(rx_column_o))
    else $error("gap code left on the receive bus");
  rx_col_pace_a: assert property ($changed(rx_column_o)
    |-> tx_edge_recent)
    else $error("receive column moved away from a column edge");
endmodule // xaui_lane_assertions

bind xaui_ipg_ctc_lane_datapath xaui_lane_assertions chk
(
  .mclk_i, .resetn_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .tx_clock_lane_first_i,
  .tx_serial_oe_o, .rx_column_o, .rx_column_oe_o, .tx_power_up_o,
  .rx_power_up_o, .emphasis_level_o
);

// ===== tb/xaui_lane_partner.sv
/*
  Far-side model: the parallel source sending gap idles, or a repeating
  link status, data and terminate column pattern, on the column link,
  and a link partner sending receive columns at a set rate.
*/
`timescale 1ns/1ps
module xaui_lane_partner
  import xaui_lane_pkg::*;
(
  // Receive rate (half period in ns) and column kind
  input wire logic [7:0] rx_half_i,
  input wire logic [1:0] rx_kind_i,
  // Transmit column pattern select
  input wire logic tx_pkt_i,
  // Column links
  output logic tx_clk_o,
  output column_t tx_col_o,
  output logic rx_clk_o,
  output column_t rx_col_o
);
  int n;
  // Data bytes are zero so that the replaced codes stand out in the
  // serial stream and cannot be mimicked by a shifted window.
  initial
  begin
    tx_clk_o = 1'b0;
    tx_col_o = {4'hF, {4{BYTE_IDLE}}};
    forever
    begin
      #40 tx_clk_o = 1'b1;
      #40 tx_clk_o = 1'b0;
      n = (n == 2) ? 0 : n + 1;
      if (!tx_pkt_i)
        tx_col_o = {4'hF, {4{BYTE_IDLE}}};
      else if (n == 0)
        tx_col_o = {4'h1, 24'h000000, CODE_LSM};
      else if (n == 1)
        tx_col_o = '0;
      else
        tx_col_o = {4'hE, BYTE_IDLE, BYTE_IDLE, BYTE_TERM, 8'h00};
    end
  end
  // Columns change after the falling edge so they are settled at rise.
  initial
  begin
    rx_clk_o = 1'b0;
    rx_col_o = '0;
    forever
    begin
      #(rx_half_i) rx_clk_o = 1'b1;
      #(rx_half_i) rx_clk_o = 1'b0;
      rx_col_o.k = (rx_kind_i == 2'h0) ? 4'h0 : 4'hF;
      for (int l = 0; l < LANES; l++)
        rx_col_o.d[l] = (rx_kind_i == 2'h0) ? 8'($urandom) :
          (rx_kind_i == 2'h1) ? CODE_SKIP : CODE_ALIGN;
    end
  end
endmodule // xaui_lane_partner
